// >>> verilog/rtd_control_map.vh
// register map, field positions and timing constants of the compensation and daylight shift control
`ifndef RTD_CONTROL_MAP_VH
`define RTD_CONTROL_MAP_VH

`define RTD_ADDR_INIT_TRIM 8'h0B
`define RTD_ADDR_TEMP_COEF 8'h0C
`define RTD_ADDR_COMP_CTRL 8'h0D
`define RTD_ADDR_STATUS 8'h0F
`define RTD_ADDR_FOUT_CTRL 8'h11
`define RTD_ADDR_FWD_MONTH 8'h15
`define RTD_ADDR_FWD_WDAY 8'h16
`define RTD_ADDR_FWD_DATE 8'h17
`define RTD_ADDR_FWD_HOUR 8'h18
`define RTD_ADDR_REV_MONTH 8'h19
`define RTD_ADDR_REV_WDAY 8'h1A
`define RTD_ADDR_REV_DATE 8'h1B
`define RTD_ADDR_REV_HOUR 8'h1C

`define RTD_COMP_ENABLE_BIT 7
`define RTD_COMP_BATT_HI 6
`define RTD_COMP_BATT_LO 5
`define RTD_COMP_TRIM_HI 4
`define RTD_COMP_TRIM_W 5
`define RTD_MONTH_ENABLE_BIT 7
`define RTD_MONTH_HI 4
`define RTD_WDAY_SELECT_BIT 6
`define RTD_WDAY_WEEK_HI 5
`define RTD_WDAY_WEEK_LO 3
`define RTD_WDAY_DAY_HI 2
`define RTD_WEEK_LAST 3'h7
`define RTD_STATUS_APPLIED_BIT 3
`define RTD_FOUT_ENABLE_BIT 3
`define RTD_FOUT_SHIFT_HI 2

`define RTD_COMP_PERIOD_S 60
`define RTD_SEC_TICK_S 1
`define RTD_COMP_PERIOD_TICKS (`RTD_COMP_PERIOD_S / `RTD_SEC_TICK_S)
`define RTD_CLK_HZ 50000000
`define RTD_FOUT_BASE_HZ 1
`define RTD_FOUT_HALF_CYCLES (`RTD_CLK_HZ / (2 * `RTD_FOUT_BASE_HZ))
`define RTD_DAYS_PER_WEEK 6'h07
`define RTD_FEB 4'h2
`define RTD_ZERO_BCD 8'h00
`define RTD_TEMP_REF 10'h064

`endif

// >>> verilog/rtd_control.v
// temperature compensation and automatic daylight shift control of the real time clock
// How it works
// [R1] at power-up the five factory trim bits are recalled into the low bits of the control register at 0Dh.
// [R2] bit 7 of the control register enables temperature sensing and periodic correction.
// [R3] with sensing enabled and main supply present a correction runs every 60 seconds.
// [R4] bits 6 and 5 select whether and how often correction runs on battery.
// [R5] software reads the control register and writes it back with the trim bits unchanged.
// [R6] each write of the control register with the enable set starts a correction, loading new trims if the temperature moved.
// [R7] software leaves the initial trim at 0Bh and the coefficient at 0Ch alone, except to recalibrate.
// [R8] at the programmed forward or reverse moment the time is moved ahead or back, every year.
// [R9] bit 7 of the forward month register at 15h enables the daylight shift beside the BCD month.
// [R10] the week/day registers at 16h and 1Ah hold week, weekday and the week/day versus date select.
// [R11] the shift hour registers at 18h and 1Ch and the months are plain BCD in 24-hour form.
// [R12] week code 7 means the last matching weekday of the month, for four or five week months.
// [R13] the applied bit is 1 after the forward shift and 0 after the reverse shift, power-up or disable.
// [R14] the open-drain frequency pin can drive a selectable square wave including 1 Hz.
// [R15] the applied bit is read-only and setting the time never sets it.
// [R16] week/day bit 6 selects week matching, bits 5:3 the week with 7 as last, bits 2:0 the day with 0 as Sunday.
// [R17] a date register is ignored while its week/day select bit is set.
`timescale 1ns/1ps
`default_nettype none
`include "rtd_control_map.vh"

module rtd_control #(
    parameter FOUT_HALF_CYCLES = `RTD_FOUT_HALF_CYCLES
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    input wire [4:0] factory_comp_trim_i,
    input wire [7:0] factory_init_trim_i,
    input wire [7:0] factory_temp_coef_i,
    input wire vdd_present_i,
    input wire sec_tick_i,
    input wire [9:0] temp_i,
    input wire [7:0] year_i,
    input wire [7:0] month_i,
    input wire [7:0] date_i,
    input wire [2:0] week_day_i,
    input wire [7:0] hour_i,
    input wire [7:0] minute_i,
    input wire [7:0] second_i,
    output reg [5:0] analog_freq_trim_o,
    output reg [4:0] digital_freq_trim_o,
    output reg comp_cycle_o,
    output reg dst_forward_o,
    output reg dst_reverse_o,
    output reg daylight_shift_applied_o,
    output reg fout_o,
    output reg fout_oe_n_o
);

    reg [7:0] initial_freq_trim;
    reg [7:0] temp_coefficient_trim;
    reg [7:0] temp_comp_control;
    reg [7:0] fout_control;
    reg [7:0] dst_forward_month_enable;
    reg [7:0] dst_forward_week_day;
    reg [7:0] dst_forward_date;
    reg [7:0] dst_forward_hour;
    reg [7:0] dst_reverse_month;
    reg [7:0] dst_reverse_week_day;
    reg [7:0] dst_reverse_date;
    reg [7:0] dst_reverse_hour;
    reg recall_pending;
    reg vdd_meta;
    reg vdd_sync;
    reg [7:0] sec_count;
    reg [9:0] last_temp;
    reg comp_start;
    reg [31:0] fout_count;
    reg fout_wave;

    wire ctrl_write = reg_wr_i && (reg_addr_i == `RTD_ADDR_COMP_CTRL);
    wire temp_sense_enable = temp_comp_control[`RTD_COMP_ENABLE_BIT];
    wire [1:0] batt_mode = temp_comp_control[`RTD_COMP_BATT_HI:`RTD_COMP_BATT_LO];
    wire daylight_shift_enable = dst_forward_month_enable[`RTD_MONTH_ENABLE_BIT];

    // bcd byte to binary, tens digit limited to what the calendar uses
    function [6:0] bcd2bin;
        input [7:0] d;
        begin
            bcd2bin = ({3'h0, d[7:4]} << 3) + ({3'h0, d[7:4]} << 1) + {3'h0, d[3:0]};
        end
    endfunction

    // days in the current month, leap years every fourth year through 2099
    function [4:0] month_days;
        input [3:0] m;
        input [6:0] y;
        begin
            if (m == `RTD_FEB) begin
                month_days = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            end else if ((m == 4'h4) || (m == 4'h6) || (m == 4'h9) || (m == 4'hB)) begin
                month_days = 5'h1E;
            end else begin
                month_days = 5'h1F;
            end
        end
    endfunction

    // one moment match: month, then week/day or date, then hour at the top of the hour
    function moment_hit;
        input [7:0] mon_reg;
        input [7:0] wday_reg;
        input [7:0] date_reg;
        input [7:0] hour_reg;
        input [7:0] cur_month;
        input [7:0] cur_date;
        input [2:0] cur_wday;
        input [7:0] cur_hour;
        input [7:0] cur_year;
        reg [3:0] mb;
        reg [4:0] db;
        reg [4:0] dim;
        reg [2:0] wk;
        reg [5:0] lo;
        reg day_ok;
        reg [6:0] mon_bin;
        reg [6:0] date_bin;
        begin
            mon_bin = bcd2bin(cur_month);
            date_bin = bcd2bin(cur_date);
            mb = mon_bin[3:0];
            db = date_bin[4:0];
            dim = month_days(mb, bcd2bin(cur_year));
            wk = wday_reg[`RTD_WDAY_WEEK_HI:`RTD_WDAY_WEEK_LO];
            lo = 6'h00;
            day_ok = 1'b0;
            if (wday_reg[`RTD_WDAY_SELECT_BIT]) begin // see [R16] see [R17]
                if (cur_wday == wday_reg[`RTD_WDAY_DAY_HI:0]) begin
                    if (wk == `RTD_WEEK_LAST) begin
                        day_ok = ({1'b0, db} + `RTD_DAYS_PER_WEEK) > {1'b0, dim}; // see [R12]
                    end else if (wk != 3'h0) begin
                        lo = ({3'h0, wk} - 6'h01) * `RTD_DAYS_PER_WEEK;
                        day_ok = ({1'b0, db} > lo) && ({1'b0, db} <= lo + `RTD_DAYS_PER_WEEK);
                    end
                end
            end else begin
                day_ok = (cur_date == date_reg);
            end
            moment_hit = (cur_month[`RTD_MONTH_HI:0] == mon_reg[`RTD_MONTH_HI:0]) && day_ok && // see [R11]
                         (cur_hour == hour_reg);
        end
    endfunction

    wire top_of_hour = sec_tick_i && (minute_i == `RTD_ZERO_BCD) && (second_i == `RTD_ZERO_BCD);
    wire fwd_hit = moment_hit(dst_forward_month_enable, dst_forward_week_day, dst_forward_date,
                              dst_forward_hour, month_i, date_i, week_day_i, hour_i, year_i);
    wire rev_hit = moment_hit(dst_reverse_month, dst_reverse_week_day, dst_reverse_date,
                              dst_reverse_hour, month_i, date_i, week_day_i, hour_i, year_i);
    // the applied flag gates each direction so the repeated hour after setting back cannot re-trigger
    wire do_forward = daylight_shift_enable && !daylight_shift_applied_o && top_of_hour && fwd_hit;
    wire do_reverse = daylight_shift_enable && daylight_shift_applied_o && top_of_hour && rev_hit;

    // battery codes stretch the interval: 01 one, 10 two, 11 three periods; 00 holds off on battery
    wire [7:0] period_mult = vdd_sync ? 8'h01 : {6'h00, batt_mode};
    wire periodic_run = temp_sense_enable && (period_mult != 8'h00);
    // the longest interval is three periods, which still fits the 8-bit second counter
    wire [31:0] period_prod = period_mult * `RTD_COMP_PERIOD_TICKS;
    wire [7:0] period_ticks = period_prod[7:0];

    wire signed [10:0] temp_delta = $signed({1'b0, temp_i}) - $signed({1'b0, `RTD_TEMP_REF});
    wire signed [19:0] temp_corr = temp_delta * $signed({1'b0, temp_coefficient_trim});
    wire [4:0] next_digital = temp_comp_control[`RTD_COMP_TRIM_HI:0] + temp_corr[12:8];

    wire [31:0] fout_half = FOUT_HALF_CYCLES >> fout_control[`RTD_FOUT_SHIFT_HI:0];

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            vdd_meta <= 1'b0;
            vdd_sync <= 1'b0;
        end else if (ce_i) begin
            vdd_meta <= vdd_present_i;
            vdd_sync <= vdd_meta;
        end
    end

    // register file and recall
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            recall_pending <= 1'b1;
            initial_freq_trim <= 8'h00;
            temp_coefficient_trim <= 8'h00;
            temp_comp_control <= 8'h00;
            fout_control <= 8'h00;
            dst_forward_month_enable <= 8'h00;
            dst_forward_week_day <= 8'h00;
            dst_forward_date <= 8'h00;
            dst_forward_hour <= 8'h00;
            dst_reverse_month <= 8'h00;
            dst_reverse_week_day <= 8'h00;
            dst_reverse_date <= 8'h00;
            dst_reverse_hour <= 8'h00;
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            if (recall_pending) begin
                recall_pending <= 1'b0;
                initial_freq_trim <= factory_init_trim_i;
                temp_coefficient_trim <= factory_temp_coef_i;
                temp_comp_control <= {3'h0, factory_comp_trim_i}; // see [R1]
            end else if (reg_wr_i) begin
                if (reg_addr_i == `RTD_ADDR_INIT_TRIM) begin
                    initial_freq_trim <= reg_wdata_i; // see [R7]
                end else if (reg_addr_i == `RTD_ADDR_TEMP_COEF) begin
                    temp_coefficient_trim <= reg_wdata_i;
                end else if (reg_addr_i == `RTD_ADDR_COMP_CTRL) begin
                    temp_comp_control <= reg_wdata_i; // see [R5]
                end else if (reg_addr_i == `RTD_ADDR_FOUT_CTRL) begin
                    fout_control <= {4'h0, reg_wdata_i[3:0]};
                end else if (reg_addr_i == `RTD_ADDR_FWD_MONTH) begin
                    dst_forward_month_enable <= reg_wdata_i; // see [R9]
                end else if (reg_addr_i == `RTD_ADDR_FWD_WDAY) begin
                    dst_forward_week_day <= reg_wdata_i; // see [R10]
                end else if (reg_addr_i == `RTD_ADDR_FWD_DATE) begin
                    dst_forward_date <= reg_wdata_i;
                end else if (reg_addr_i == `RTD_ADDR_FWD_HOUR) begin
                    dst_forward_hour <= reg_wdata_i;
                end else if (reg_addr_i == `RTD_ADDR_REV_MONTH) begin
                    dst_reverse_month <= reg_wdata_i;
                end else if (reg_addr_i == `RTD_ADDR_REV_WDAY) begin
                    dst_reverse_week_day <= reg_wdata_i;
                end else if (reg_addr_i == `RTD_ADDR_REV_DATE) begin
                    dst_reverse_date <= reg_wdata_i;
                end else if (reg_addr_i == `RTD_ADDR_REV_HOUR) begin
                    dst_reverse_hour <= reg_wdata_i;
                end
            end
            if (reg_rd_i) begin
                if (reg_addr_i == `RTD_ADDR_INIT_TRIM) begin
                    reg_rdata_o <= initial_freq_trim;
                end else if (reg_addr_i == `RTD_ADDR_TEMP_COEF) begin
                    reg_rdata_o <= temp_coefficient_trim;
                end else if (reg_addr_i == `RTD_ADDR_COMP_CTRL) begin
                    reg_rdata_o <= temp_comp_control;
                end else if (reg_addr_i == `RTD_ADDR_STATUS) begin
                    reg_rdata_o <= {7'h00, daylight_shift_applied_o} << `RTD_STATUS_APPLIED_BIT;
                end else if (reg_addr_i == `RTD_ADDR_FOUT_CTRL) begin
                    reg_rdata_o <= fout_control;
                end else if (reg_addr_i == `RTD_ADDR_FWD_MONTH) begin
                    reg_rdata_o <= dst_forward_month_enable;
                end else if (reg_addr_i == `RTD_ADDR_FWD_WDAY) begin
                    reg_rdata_o <= dst_forward_week_day;
                end else if (reg_addr_i == `RTD_ADDR_FWD_DATE) begin
                    reg_rdata_o <= dst_forward_date;
                end else if (reg_addr_i == `RTD_ADDR_FWD_HOUR) begin
                    reg_rdata_o <= dst_forward_hour;
                end else if (reg_addr_i == `RTD_ADDR_REV_MONTH) begin
                    reg_rdata_o <= dst_reverse_month;
                end else if (reg_addr_i == `RTD_ADDR_REV_WDAY) begin
                    reg_rdata_o <= dst_reverse_week_day;
                end else if (reg_addr_i == `RTD_ADDR_REV_DATE) begin
                    reg_rdata_o <= dst_reverse_date;
                end else if (reg_addr_i == `RTD_ADDR_REV_HOUR) begin
                    reg_rdata_o <= dst_reverse_hour;
                end else begin
                    reg_rdata_o <= 8'h00;
                end
            end
        end
    end

    // compensation scheduling and trim update
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            sec_count <= 8'h00;
            comp_start <= 1'b0;
            comp_cycle_o <= 1'b0;
            last_temp <= 10'h000;
            analog_freq_trim_o <= 6'h00;
            digital_freq_trim_o <= 5'h00;
        end else if (ce_i) begin
            comp_start <= 1'b0;
            if (ctrl_write && reg_wdata_i[`RTD_COMP_ENABLE_BIT]) begin
                comp_start <= 1'b1; // see [R6]
                sec_count <= 8'h00;
            end else if (!periodic_run) begin
                sec_count <= 8'h00; // see [R2] see [R4]
            end else if (sec_tick_i) begin
                if (sec_count + 8'h01 >= period_ticks) begin
                    sec_count <= 8'h00;
                    comp_start <= 1'b1; // see [R3]
                end else begin
                    sec_count <= sec_count + 8'h01;
                end
            end
            comp_cycle_o <= comp_start;
            // the write lands on the same edge that sets comp_start, so the new trim bits are used here
            if (comp_start && (temp_i != last_temp)) begin
                last_temp <= temp_i;
                analog_freq_trim_o <= initial_freq_trim[5:0];
                digital_freq_trim_o <= next_digital; // see [R6]
            end
        end
    end

    // daylight shift requests and the applied flag
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            dst_forward_o <= 1'b0;
            dst_reverse_o <= 1'b0;
            daylight_shift_applied_o <= 1'b0; // see [R13]
        end else if (ce_i) begin
            dst_forward_o <= do_forward; // see [R8]
            dst_reverse_o <= do_reverse; // see [R8]
            if (!daylight_shift_enable) begin
                daylight_shift_applied_o <= 1'b0; // see [R13]
            end else if (do_forward) begin
                daylight_shift_applied_o <= 1'b1;
            end else if (do_reverse) begin
                daylight_shift_applied_o <= 1'b0; // see [R13]
            end
        end
    end

    // square wave on the open-drain pin: low half drives, high half releases to the pull-up
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            fout_count <= 32'h00000000;
            fout_wave <= 1'b1;
            fout_o <= 1'b0;
            fout_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            fout_o <= 1'b0;
            if (!fout_control[`RTD_FOUT_ENABLE_BIT]) begin
                fout_count <= 32'h00000000;
                fout_wave <= 1'b1;
            end else if (fout_count + 32'h00000001 >= fout_half) begin
                fout_count <= 32'h00000000;
                fout_wave <= !fout_wave; // see [R14]
            end else begin
                fout_count <= fout_count + 32'h00000001;
            end
            fout_oe_n_o <= !(fout_control[`RTD_FOUT_ENABLE_BIT] && !fout_wave);
        end
    end

endmodule // rtd_control
`default_nettype wire

// >>> testbench/rtd_control_properties.sv
// checker: timing relations of the compensation and daylight shift control
`timescale 1ns/1ps
`default_nettype none
module rtd_control_properties (
    input wire clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire sec_tick_i,
    input wire [7:0] minute_i,
    input wire [7:0] second_i,
    input wire [4:0] digital_freq_trim_o,
    input wire comp_cycle_o,
    input wire dst_forward_o,
    input wire dst_reverse_o,
    input wire daylight_shift_applied_o,
    input wire fout_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire ctrl_wr = ce_i && reg_wr_i && reg_addr_i == 8'h0D && reg_wdata_i[7];
    comp_on_write_a: assert property (ctrl_wr |-> ##[1:3] comp_cycle_o)
        else $error("no compensation cycle after an enabling control write");
    comp_pulse_a: assert property (comp_cycle_o |=> !comp_cycle_o)
        else $error("compensation pulse longer than one cycle");
    trim_cause_a: assert property ($changed(digital_freq_trim_o) |-> comp_cycle_o)
        else $error("digital trim moved outside a compensation cycle");
    fwd_moment_a: assert property (dst_forward_o |-> $past(sec_tick_i) && $past(minute_i) == 8'h00
        && $past(second_i) == 8'h00) else $error("forward shift away from the top of an hour");
    shift_excl_a: assert property (!(dst_forward_o && dst_reverse_o))
        else $error("forward and reverse shift together");
    fwd_flag_a: assert property (dst_forward_o |-> daylight_shift_applied_o)
        else $error("applied flag low with a forward shift");
    rev_flag_a: assert property (dst_reverse_o |-> !daylight_shift_applied_o)
        else $error("applied flag high with a reverse shift");
    flag_rise_a: assert property ($rose(daylight_shift_applied_o) |-> dst_forward_o)
        else $error("applied flag set without a forward shift");
    // the disabling write lands one edge and clears the flag the next, so it is seen two samples back
    flag_fall_a: assert property ($fell(daylight_shift_applied_o) |-> dst_reverse_o ||
        ($past(reg_wr_i, 2) && $past(reg_addr_i, 2) == 8'h15 && !$past(reg_wdata_i[7], 2)))
        else $error("applied flag cleared without cause");
    rdata_hold_a: assert property ($changed(reg_rdata_o) |-> $past(reg_rd_i))
        else $error("read data changed without a read");
    fout_low_a: assert property (!fout_o)
        else $error("frequency pin driven high");
    cover property (ctrl_wr ##[1:3] comp_cycle_o);
    cover property (dst_forward_o);
    cover property (dst_reverse_o);
endmodule // rtd_control_properties
bind rtd_control rtd_control_properties chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sec_tick_i(sec_tick_i), .minute_i(minute_i), .second_i(second_i),
    .digital_freq_trim_o(digital_freq_trim_o), .comp_cycle_o(comp_cycle_o), .dst_forward_o(dst_forward_o),
    .dst_reverse_o(dst_reverse_o), .daylight_shift_applied_o(daylight_shift_applied_o), .fout_o(fout_o));
`default_nettype wire

// >>> testbench/rtd_host_model.sv
// host model: byte-port register master that keeps the compensation enable sequence
`timescale 1ns/1ps
`default_nettype none
module rtd_host_model (
    input wire logic clk_i,
    input wire [7:0] reg_rdata_i,
    output logic [7:0] reg_addr_o = 8'h00,
    output logic [7:0] reg_wdata_o = 8'h00,
    output logic reg_wr_o = 1'b0,
    output logic reg_rd_o = 1'b0
);
    // released lines show the inverse so a stale value is never taken for good data
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        reg_addr_o <= addr;
        reg_wdata_o <= data;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~addr;
        reg_wdata_o <= ~data;
    endtask
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_i);
        reg_addr_o <= addr;
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~addr;
        @(negedge clk_i);
        data = reg_rdata_i;
    endtask
    // the trim registers at 0Bh and 0Ch are only ever read here
    task automatic enable_comp(input logic [1:0] batt_mode);
        logic [7:0] cur;
        read_reg(8'h0D, cur);
        write_reg(8'h0D, {1'b1, batt_mode, cur[4:0]});
    endtask
endmodule // rtd_host_model
`default_nettype wire

// >>> testbench/rtd_control_tb.sv
// testbench: compensation control and daylight shift scenarios
`timescale 1ns/1ps
`default_nettype none
module rtd_control_tb;
    localparam logic [4:0] TRIM5 = 5'h13;
    localparam logic [7:0] INIT_TRIM = 8'h5A;
    localparam logic [7:0] COEF = 8'h20;
    localparam int HALF = 8;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic sec_tick_i = 1'b0;
    logic vdd_present_i = 1'b1;
    logic [9:0] temp_i = 10'h064;
    logic [7:0] month_i = 8'h01, date_i = 8'h01, hour_i = 8'h00, minute_i = 8'h00, second_i = 8'h00;
    logic [2:0] week_day_i = 3'h0;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire reg_wr, reg_rd, comp_cycle, dst_fwd, dst_rev, applied, fout, fout_oe_n;
    wire [5:0] analog_trim;
    wire [4:0] digital_trim;
    logic [7:0] rd;
    int num_errors = 0, n_tests = 0, cycles = 0, comp_count = 0, fwd_count = 0, rev_count = 0;

    rtd_control #(.FOUT_HALF_CYCLES(HALF)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .factory_comp_trim_i(TRIM5), .factory_init_trim_i(INIT_TRIM),
        .factory_temp_coef_i(COEF), .vdd_present_i(vdd_present_i), .sec_tick_i(sec_tick_i), .temp_i(temp_i),
        .year_i(8'h24), .month_i(month_i), .date_i(date_i), .week_day_i(week_day_i), .hour_i(hour_i),
        .minute_i(minute_i), .second_i(second_i), .analog_freq_trim_o(analog_trim),
        .digital_freq_trim_o(digital_trim), .comp_cycle_o(comp_cycle), .dst_forward_o(dst_fwd),
        .dst_reverse_o(dst_rev), .daylight_shift_applied_o(applied), .fout_o(fout), .fout_oe_n_o(fout_oe_n));
    rtd_host_model host (.clk_i(clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));

    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // one-cycle pulses are counted here so scenarios never miss them
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        comp_count <= comp_count + (comp_cycle === 1'b1);
        fwd_count <= fwd_count + (dst_fwd === 1'b1);
        rev_count <= rev_count + (dst_rev === 1'b1);
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tick();
        @(posedge clk_i);
        sec_tick_i <= 1'b1;
        @(posedge clk_i);
        sec_tick_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic ticks_expect(input int n, input int exp);
        int c0;
        c0 = comp_count;
        repeat (n) tick();
        check(comp_count - c0, exp);
    endtask
    task automatic at_time(input logic [7:0] mon, input logic [7:0] day);
        @(posedge clk_i);
        month_i <= mon;
        date_i <= day;
        hour_i <= 8'h02;
        tick();
    endtask

    task automatic test_recall();
        host.read_reg(8'h0B, rd);
        check(rd, INIT_TRIM);
        host.read_reg(8'h0C, rd);
        check(rd, COEF);
        host.read_reg(8'h0D, rd);
        check(rd, {3'h0, TRIM5});
        host.read_reg(8'h0F, rd);
        check(rd[3], 1'b0);
    endtask
    task automatic test_comp();
        host.enable_comp(2'b00);
        host.read_reg(8'h0D, rd);
        check(rd, {3'h4, TRIM5});
        @(posedge clk_i);
        temp_i <= 10'h074;
        host.write_reg(8'h0D, {3'h4, TRIM5});
        repeat (4) @(posedge clk_i);
        check(analog_trim, INIT_TRIM[5:0]);
        check(digital_trim, TRIM5 + 5'h02);
        ticks_expect(59, 0);
        ticks_expect(1, 1);
        // enable low with a battery code set: neither the write nor the ticks may start a cycle
        host.write_reg(8'h0D, {3'h3, TRIM5});
        ticks_expect(60, 0);
        vdd_present_i <= 1'b0;
        host.enable_comp(2'b00);
        repeat (4) @(posedge clk_i);
        ticks_expect(60, 0);
        host.enable_comp(2'b01);
        repeat (4) @(posedge clk_i);
        ticks_expect(60, 1);
        ce_i <= 1'b0;
        ticks_expect(60, 0);
        ce_i <= 1'b1;
        ticks_expect(59, 0);
        ticks_expect(1, 1);
        host.enable_comp(2'b11);
        repeat (4) @(posedge clk_i);
        ticks_expect(179, 0);
        ticks_expect(1, 1);
    endtask
    task automatic test_dst();
        logic [7:0] tbl [8] = '{8'h84, 8'h48, 8'h00, 8'h02, 8'h10, 8'h78, 8'h00, 8'h02};
        for (int i = 0; i < 8; i++) begin
            host.write_reg(8'h15 + i[7:0], tbl[i]);
            host.read_reg(8'h15 + i[7:0], rd);
            check(rd, tbl[i]);
        end
        at_time(8'h04, 8'h08);
        check(fwd_count, 0);
        at_time(8'h04, 8'h01);
        check({fwd_count[7:0], applied}, {8'h01, 1'b1});
        host.write_reg(8'h0F, 8'h00);
        host.read_reg(8'h0F, rd);
        check(rd, 8'h08);
        at_time(8'h10, 8'h24);
        check(rev_count, 0);
        at_time(8'h10, 8'h31);
        check({rev_count[7:0], applied}, {8'h01, 1'b0});
        at_time(8'h04, 8'h01);
        host.write_reg(8'h15, 8'h04);
        at_time(8'h04, 8'h01);
        check({fwd_count[7:0], applied}, {8'h02, 1'b0});
        // date matching: select bit clear, the date register decides the day
        host.write_reg(8'h16, 8'h00);
        host.write_reg(8'h17, 8'h15);
        host.write_reg(8'h15, 8'h84);
        at_time(8'h04, 8'h15);
        check({fwd_count[7:0], applied}, {8'h03, 1'b1});
    endtask
    task automatic test_reset();
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        test_recall();
    endtask
    task automatic test_fout();
        int n;
        for (int s = 0; s < 2; s++) begin
            host.write_reg(8'h11, 8'h08 + s[7:0]);
            repeat (2) @(negedge fout_oe_n);
            @(negedge clk_i);
            n = 0;
            while (fout_oe_n === 1'b0) begin
                n++;
                @(negedge clk_i);
            end
            check({n[7:0], fout}, {8'(HALF >> s), 1'b0});
        end
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        test_recall();
        test_comp();
        test_dst();
        test_reset();
        test_fout();
        summarize();
    end
endmodule // rtd_control_tb
`default_nettype wire
